// ---- core/dip_pkg.sv ----
// dip_pkg: register map, field layout, reset values and encodings of the
// isolated input pin block.
// assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses.
package dip_pkg;

  // ==========================================================
  // register map (byte address is four times the index)
  localparam int         ADDR_W        = 8;
  localparam logic [5:0] HOMING_INDEX  = 6'h04;
  localparam logic [5:0] CFG_INDEX     = 6'h09;
  localparam logic [5:0] PORT_INDEX    = 6'h0A;
  localparam logic [5:0] STATUS_INDEX  = 6'h20;

  // ==========================================================
  // input_pin_config fields
  localparam int          ENC_EN_BIT     = 12;
  localparam int          SPD_FN_LSB     = 10;
  localparam int          INH_FN_LSB     = 8;
  localparam int          STEP_MODE_LSB  = 4;
  localparam int          POL_LSB        = 0;
  localparam logic [15:0] CFG_USED_MASK  = 16'h1FFF;
  localparam logic [15:0] CFG_RESET      = 16'h0000;

  // homing configuration and port data fields
  localparam int         HOME_MODE_LSB   = 1;
  localparam logic [2:0] HOME_MODE_RESET = 3'h0;
  localparam int         PORT_AUX_LSB    = 4;
  localparam logic [2:0] AUX_OUT_RESET   = 3'h0;

  // ==========================================================
  // function encodings
  localparam logic [1:0] SPD_FN_CURRENT  = 2'h0;
  localparam logic [1:0] SPD_FN_SPEED    = 2'h1;
  localparam logic [1:0] INH_FN_INHIBIT  = 2'h0;
  localparam logic [1:0] INH_FN_HOME     = 2'h1;
  localparam logic [1:0] INH_FN_MOTION   = 2'h2;
  localparam logic [3:0] STEP_MODE_DIR   = 4'h0;
  localparam logic [1:0] HOME_SEL_FLAG   = 2'h0;
  localparam logic [1:0] HOME_SEL_INDEX  = 2'h1;

  // ==========================================================
  // bus answers and pin idle level
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  localparam logic       PIN_IDLE_LEVEL  = 1'b1;

endpackage

// ---- core/dip_in_sync.sv ----
// dip_in_sync: two-stage synchroniser, polarity and active-edge detect per pin.
// assumes pins idle high through a weak pull-up.
`timescale 1ns/1ps
`default_nettype none
module dip_in_sync
  import dip_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] raw,
  input  wire logic [WIDTH-1:0] pol,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] edge_hit
);

  // ==========================================================
  // per-pin chain
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic meta_reg, meta_next, sync_reg, sync_next, prev_reg, prev_next;
      logic active;
      always_comb begin
        meta_next = raw[i];
        sync_next = meta_reg;
        active    = pol[i] ? sync_reg : ~sync_reg;
        prev_next = active;
      end
      // prev resets inactive so an inverted floating pin fires at once
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg <= PIN_IDLE_LEVEL;
          sync_reg <= PIN_IDLE_LEVEL;
          prev_reg <= 1'b0;
        end else if (ce) begin
          meta_reg <= meta_next; // RULE19
          sync_reg <= sync_next;
          prev_reg <= prev_next;
        end
      end
      assign level[i]    = active; // RULE2 RULE3
      assign edge_hit[i] = active & ~prev_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- core/dip_fault_hold.sv ----
// dip_fault_hold: drive fault flags, non-thermal and thermal.
// assumes fault events are one-cycle pulses from the drive core.
`timescale 1ns/1ps
`default_nettype none
module dip_fault_hold
  import dip_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic fault_event,
  input  wire logic thermal_event,
  input  wire logic overtemp_present,
  input  wire logic clear_req,
  output logic      fault_nonthermal,
  output logic      fault_thermal
);

  // ==========================================================
  // flags
  logic nonthermal_reg, nonthermal_next, thermal_reg, thermal_next;

  always_comb begin
    nonthermal_next = nonthermal_reg;
    thermal_next    = thermal_reg;
    if (clear_req)
      nonthermal_next = 1'b0; // RULE15
    if (fault_event)
      nonthermal_next = 1'b1; // set wins over clear
    if (!overtemp_present)
      thermal_next = 1'b0; // RULE16
    if (thermal_event)
      thermal_next = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nonthermal_reg <= 1'b0;
      thermal_reg    <= 1'b0;
    end else if (ce) begin
      nonthermal_reg <= nonthermal_next;
      thermal_reg    <= thermal_next;
    end
  end

  assign fault_nonthermal = nonthermal_reg;
  assign fault_thermal    = thermal_reg;

  // ==========================================================
  // checks
  property p_thermal_keep;
    @(posedge aclk) disable iff (!aresetn)
      ce && thermal_reg && overtemp_present |=> thermal_reg;
  endproperty
  a_thermal_keep: assert property (p_thermal_keep) else $error("thermal fault dropped"); // RULE16

  property p_nonthermal_clear;
    @(posedge aclk) disable iff (!aresetn)
      ce && clear_req && !fault_event |=> !nonthermal_reg;
  endproperty
  a_nonthermal_clear: assert property (p_nonthermal_clear) else $error("fault kept"); // RULE15

endmodule
`default_nettype wire

// ---- core/dip_top.sv ----
// dip_top: isolated input pins and auxiliary pins of the control_connector,
// configured through input_pin_config over AXI4-Lite.
// assumes pins and core handshakes synchronous to aclk; aux pins two-way.
// Contract
// RULE1: config word holds encoder enable, two functions, step mode, four polarities
// RULE2: each input acts on falling edge; its polarity bit selects rising
// RULE3: pull-up stays, so floating inverted input is active at once
// RULE4: input levels always readable; port data writes drive aux outputs
// RULE5: encoder bit low: aux pins are index, A, B and readable
// RULE6: encoder bit high: aux pins are general purpose outputs
// RULE7: flag homing: pin two is homing switch, its function ignored
// RULE8: index homing: pin two takes role from its function field
// RULE9: function 0: active edge asks current cut to cutback level
// RULE10: function 1: high picks primary speed, low picks alternate_rate_pair
// RULE11: jog follows speed input; profile samples once at start
// RULE12: inhibit: edge zeroes phase current until input goes inactive
// RULE13: home function: each active edge starts a home cycle
// RULE14: motion inhibit: edge stops motion, blocks serial motion bits
// RULE15: inhibit, home or motion inhibit activation clears non-thermal fault
// RULE16: thermal fault persists until overtemperature indication clears
// RULE17: modes 0,1 home on flag; 2,3 on index; odd decelerate
// RULE18: step/dir mode: one microstep per active step edge, dir level
// RULE19: inputs synchronised first; reserved function codes give no function
// RULE20: host writes only defined codes and selects index homing first
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dip_top
  import dip_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [3:0]        ctl_in,
  input  wire logic [2:0]        aux_in,
  output logic [2:0]             aux_out,
  output logic [2:0]             aux_oe,
  input  wire logic              jog_active,
  input  wire logic              profile_start,
  input  wire logic              profile_busy,
  input  wire logic              fault_event,
  input  wire logic              thermal_event,
  input  wire logic              overtemp_present,
  output logic                   enc_index,
  output logic                   enc_a,
  output logic                   enc_b,
  output logic                   home_flag_hit,
  output logic                   home_stop_now,
  output logic                   current_reduce_pulse,
  output logic                   alternate_rate_pair_sel,
  output logic                   phase_current_off,
  output logic                   home_start_pulse,
  output logic                   motion_stop_pulse,
  output logic                   motion_inhibit,
  output logic                   fault_clear_pulse,
  output logic                   step_pulse,
  output logic                   step_dir,
  output logic                   fault_nonthermal,
  output logic                   fault_thermal
);

  // ==========================================================
  // input conditioning
  logic [3:0]  lvl, edg;
  logic [2:0]  aux_lvl, aux_edg;
  logic [15:0] cfg_reg, cfg_next;

  dip_in_sync #(.WIDTH(4)) u_ctl_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .raw      (ctl_in),
    .pol      (cfg_reg[POL_LSB +: 4]),
    .level    (lvl),
    .edge_hit (edg)
  );

  // aux pins pass straight: index is active high
  dip_in_sync #(.WIDTH(3)) u_aux_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .raw      (aux_in),
    .pol      (3'h7),
    .level    (aux_lvl),
    .edge_hit (aux_edg)
  );

  // ==========================================================
  // bus slave and registers
  logic              awready_reg, awready_next, wready_reg, wready_next;
  logic              aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next, araddr_w;
  logic [31:0]       wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [1:0]        wstrb_reg, wstrb_next;
  logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic              arready_reg, arready_next, do_write;
  logic [2:0]        home_mode_reg, home_mode_next, aux_out_reg, aux_out_next;
  logic [15:0]       wr_val;
  logic [5:0]        wr_idx, rd_idx;

  always_comb begin
    awready_next   = awready_reg;
    wready_next    = wready_reg;
    aw_have_next   = aw_have_reg;
    w_have_next    = w_have_reg;
    awaddr_next    = awaddr_reg;
    wdata_next     = wdata_reg;
    wstrb_next     = wstrb_reg;
    bvalid_next    = bvalid_reg;
    bresp_next     = bresp_reg;
    arready_next   = arready_reg;
    rvalid_next    = rvalid_reg;
    rdata_next     = rdata_reg;
    rresp_next     = rresp_reg;
    cfg_next       = cfg_reg;
    home_mode_next = home_mode_reg;
    aux_out_next   = aux_out_reg;
    araddr_w       = s_axi_araddr;
    wr_idx         = awaddr_reg[7:2];
    rd_idx         = araddr_w[7:2];
    wr_val         = 16'h0000;
    do_write       = aw_have_reg && w_have_reg && !bvalid_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb[1:0];
      wready_next = 1'b0;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      unique case (wr_idx)
        CFG_INDEX:    wr_val = cfg_reg;
        HOMING_INDEX: wr_val = {12'h000, home_mode_reg, 1'b0};
        PORT_INDEX:   wr_val = {9'h000, aux_out_reg, 4'h0};
        STATUS_INDEX: wr_val = 16'h0000;
        default:      bresp_next = RESP_SLVERR;
      endcase
      if (wstrb_reg[0])
        wr_val[7:0] = wdata_reg[7:0];
      if (wstrb_reg[1])
        wr_val[15:8] = wdata_reg[15:8];
      if (wr_idx == CFG_INDEX)
        cfg_next = wr_val & CFG_USED_MASK; // RULE1
      if (wr_idx == HOMING_INDEX)
        home_mode_next = wr_val[HOME_MODE_LSB +: 3];
      if (wr_idx == PORT_INDEX)
        aux_out_next = wr_val[PORT_AUX_LSB +: 3]; // RULE4
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end else if (!aw_have_reg && !bvalid_reg && !(s_axi_awvalid && awready_reg))
      awready_next = 1'b1;
    if (!bvalid_reg && !w_have_reg && !(s_axi_wvalid && wready_reg))
      wready_next = 1'b1;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      rdata_next   = 32'h0000_0000;
      unique case (rd_idx)
        CFG_INDEX:    rdata_next[15:0] = cfg_reg;
        HOMING_INDEX: rdata_next[3:0]  = {home_mode_reg, 1'b0};
        PORT_INDEX:   rdata_next[6:0]  = {aux_lvl, lvl}; // RULE4 RULE5
        STATUS_INDEX: rdata_next[5:0]  = {fault_thermal, fault_nonthermal,
                                          motion_inhibit, phase_current_off,
                                          alternate_rate_pair_sel, aux_out_reg[0]};
        default:      rresp_next = RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end else if (!rvalid_reg)
      arready_next = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg   <= 1'b0;
      wready_reg    <= 1'b0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 2'h0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= RESP_OKAY;
      arready_reg   <= 1'b0;
      rvalid_reg    <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      rresp_reg     <= RESP_OKAY;
      cfg_reg       <= CFG_RESET;
      home_mode_reg <= HOME_MODE_RESET;
      aux_out_reg   <= AUX_OUT_RESET;
    end else if (ce) begin
      awready_reg   <= awready_next;
      wready_reg    <= wready_next;
      aw_have_reg   <= aw_have_next;
      w_have_reg    <= w_have_next;
      awaddr_reg    <= awaddr_next;
      wdata_reg     <= wdata_next;
      wstrb_reg     <= wstrb_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      arready_reg   <= arready_next;
      rvalid_reg    <= rvalid_next;
      rdata_reg     <= rdata_next;
      rresp_reg     <= rresp_next;
      cfg_reg       <= cfg_next;
      home_mode_reg <= home_mode_next;
      aux_out_reg   <= aux_out_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ==========================================================
  // pin functions
  logic [1:0] spd_fn, inh_fn, home_sel;
  logic       enc_en, role_home, role_cur, role_spd, fault_clr;
  logic [12:0] pin_next, pin_reg;

  always_comb begin
    spd_fn    = cfg_reg[SPD_FN_LSB +: 2];
    inh_fn    = cfg_reg[INH_FN_LSB +: 2];
    enc_en    = cfg_reg[ENC_EN_BIT];
    home_sel  = home_mode_reg[2:1];
    role_home = home_sel == HOME_SEL_FLAG; // RULE7
    role_cur  = home_sel == HOME_SEL_INDEX && spd_fn == SPD_FN_CURRENT; // RULE8 RULE19
    role_spd  = home_sel == HOME_SEL_INDEX && spd_fn == SPD_FN_SPEED;
    fault_clr = edg[2] && inh_fn != 2'h3; // RULE15 RULE19
    pin_next  = pin_reg;
    // {enc x3, flag, stop_now, cur, spd, off, home, mstop, minh, step, dir}
    pin_next[12:10] = enc_en ? 3'h0 : aux_lvl; // RULE5
    pin_next[9] = (role_home && edg[3]) ||
                  (home_sel == HOME_SEL_INDEX && !enc_en && aux_edg[2]); // RULE17
    pin_next[8] = ~home_mode_reg[0]; // RULE17
    pin_next[7] = role_cur && edg[3]; // RULE9
    // profile keeps the speed sampled at its start
    if (role_spd && (jog_active || (profile_start && !profile_busy)))
      pin_next[6] = lvl[3]; // RULE10 RULE11
    if (inh_fn != INH_FN_INHIBIT || !lvl[2])
      pin_next[5] = 1'b0;
    if (inh_fn == INH_FN_INHIBIT && edg[2])
      pin_next[5] = 1'b1; // RULE12
    pin_next[4] = inh_fn == INH_FN_HOME && edg[2]; // RULE13
    pin_next[3] = inh_fn == INH_FN_MOTION && edg[2]; // RULE14
    if (inh_fn != INH_FN_MOTION || !lvl[2])
      pin_next[2] = 1'b0;
    if (inh_fn == INH_FN_MOTION && edg[2])
      pin_next[2] = 1'b1; // RULE14
    pin_next[1] = cfg_reg[STEP_MODE_LSB +: 4] == STEP_MODE_DIR && edg[1]; // RULE18
    if (pin_next[1])
      pin_next[0] = lvl[0];
  end

  // fault clear and aux drive share this register bank
  logic       fclr_reg;
  logic [2:0] oe_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_reg  <= 13'h0000;
      fclr_reg <= 1'b0;
      oe_reg   <= 3'h0;
    end else if (ce) begin
      pin_reg  <= pin_next;
      fclr_reg <= fault_clr;
      oe_reg   <= {3{enc_en}}; // RULE6
    end
  end

  assign {enc_index, enc_a, enc_b}  = pin_reg[12:10];
  assign home_flag_hit        = pin_reg[9];
  assign home_stop_now        = pin_reg[8];
  assign current_reduce_pulse = pin_reg[7];
  assign alternate_rate_pair_sel        = pin_reg[6];
  assign phase_current_off    = pin_reg[5];
  assign home_start_pulse     = pin_reg[4];
  assign motion_stop_pulse    = pin_reg[3];
  assign motion_inhibit       = pin_reg[2];
  assign step_pulse           = pin_reg[1];
  assign step_dir             = pin_reg[0];
  assign fault_clear_pulse    = fclr_reg;
  assign aux_oe               = oe_reg;
  assign aux_out              = aux_out_reg;

  dip_fault_hold u_fault (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .ce               (ce),
    .fault_event      (fault_event),
    .thermal_event    (thermal_event),
    .overtemp_present (overtemp_present),
    .clear_req        (fclr_reg),
    .fault_nonthermal (fault_nonthermal),
    .fault_thermal    (fault_thermal)
  );

  // ==========================================================
  // checks
  property p_cfg_unused;
    @(posedge aclk) disable iff (!aresetn) cfg_reg[15:13] == 3'h0;
  endproperty
  a_cfg_unused: assert property (p_cfg_unused) else $error("unused bits set"); // RULE1

  property p_aux_dir;
    @(posedge aclk) disable iff (!aresetn)
      $past(ce) |-> aux_oe == {3{$past(enc_en)}} && (!$past(enc_en) || !enc_a);
  endproperty
  a_aux_dir: assert property (p_aux_dir) else $error("aux direction wrong"); // RULE6

  property p_enc_follow;
    @(posedge aclk) disable iff (!aresetn)
      ce && !enc_en |=> enc_index == $past(aux_lvl[2]) && enc_b == $past(aux_lvl[0]);
  endproperty
  a_enc_follow: assert property (p_enc_follow) else $error("encoder input lost"); // RULE5

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
      ce && edg[1] && cfg_reg[7:4] == STEP_MODE_DIR |=> step_pulse && step_dir == $past(lvl[0]);
  endproperty
  a_step: assert property (p_step) else $error("step missed"); // RULE18

  property p_flag_home;
    @(posedge aclk) disable iff (!aresetn)
      ce && role_home |=> home_flag_hit == $past(edg[3]) && !current_reduce_pulse;
  endproperty
  a_flag_home: assert property (p_flag_home) else $error("flag homing wrong"); // RULE7

  property p_speed_hold;
    @(posedge aclk) disable iff (!aresetn)
      ce && profile_busy && !jog_active |=> $stable(alternate_rate_pair_sel);
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("speed changed in profile"); // RULE11

  property p_inhibit;
    @(posedge aclk) disable iff (!aresetn)
      ce && inh_fn == INH_FN_INHIBIT && edg[2] |=>
        phase_current_off ##0 (ce && lvl[2]) [*2] |=> phase_current_off;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit not held"); // RULE12

  property p_home_start;
    @(posedge aclk) disable iff (!aresetn)
      ce && inh_fn == INH_FN_HOME && edg[2] |=> home_start_pulse && !motion_inhibit;
  endproperty
  a_home_start: assert property (p_home_start) else $error("home not started"); // RULE13

  property p_fault_clear;
    @(posedge aclk) disable iff (!aresetn)
      ce && fault_clr |=> fault_clear_pulse ##1
        (!$past(ce) || fault_nonthermal == $past(fault_event));
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault clear missing"); // RULE15

  c_inhibit:   cover property (@(posedge aclk) disable iff (!aresetn) $rose(phase_current_off));
  c_home:      cover property (@(posedge aclk) disable iff (!aresetn) home_start_pulse);
  c_step:      cover property (@(posedge aclk) disable iff (!aresetn) step_pulse ##[1:20] step_pulse);
  c_motion:    cover property (@(posedge aclk) disable iff (!aresetn) motion_stop_pulse);

endmodule
`default_nettype wire

// ---- tb/dip_pin_model.sv ----
// dip_pin_model: switches on the isolated inputs, far side of the aux pins.
// assumes the bench sets enables and values just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module dip_pin_model (
  input  wire logic [3:0] en,
  input  wire logic [3:0] val,
  input  wire logic [2:0] ext,
  input  wire logic [2:0] aux_out,
  input  wire logic [2:0] aux_oe,
  output logic      [3:0] ctl_in,
  output logic      [2:0] aux_in
);
  // released switch floats high through the weak pull-up
  assign ctl_in = (en & val) | ~en;
  // wire level resolves from both drivers of the two-way pin
  assign aux_in = (aux_oe & aux_out) | (~aux_oe & ext);
endmodule
`default_nettype wire

// ---- tb/dip_top_tb.sv ----
// dip_top_tb: self-checking bench for dip_top over AXI4-Lite and pins.
// assumes read and write answers come in request order.
`timescale 1ns/1ps
`default_nettype none
module dip_top_tb;
  import dip_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3, ctl_in, en = 0, val = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, qb[$];
  logic [33:0] qr[$];
  logic [2:0] aux_in, aux_out, aux_oe, r3, ext = 0;
  logic jog_active = 0, profile_start = 0, profile_busy = 0;
  logic fault_event = 0, thermal_event = 0, overtemp_present = 0;
  logic enc_index, enc_a, enc_b, home_flag_hit, home_stop_now, current_reduce_pulse;
  logic alternate_rate_pair_sel, phase_current_off, home_start_pulse, motion_stop_pulse, motion_inhibit;
  logic fault_clear_pulse, step_pulse, step_dir, fault_nonthermal, fault_thermal;
  int n_fail = 0, cmp_count = 0, s, t, u, pc[6] = '{default: 0};
  wire logic [5:0] pv = {fault_clear_pulse, home_flag_hit, current_reduce_pulse,
                         motion_stop_pulse, home_start_pulse, step_pulse};
  dip_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ctl_in, .aux_in, .aux_out, .aux_oe, .jog_active,
    .profile_start, .profile_busy, .fault_event, .thermal_event, .overtemp_present, .enc_index,
    .enc_a, .enc_b, .home_flag_hit, .home_stop_now, .current_reduce_pulse, .alternate_rate_pair_sel,
    .phase_current_off, .home_start_pulse, .motion_stop_pulse, .motion_inhibit,
    .fault_clear_pulse, .step_pulse, .step_dir, .fault_nonthermal, .fault_thermal);
  dip_pin_model pins (.en, .val, .ext, .aux_out, .aux_oe, .ctl_in, .aux_in);
  always #5 aclk = ~aclk;
  // ==========================================
  // checks, queue monitor, bus tasks
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // pulses last one cycle, so count them rather than poll
  always @(posedge aclk) begin
    foreach (pc[i]) pc[i] += int'(pv[i] === 1'b1);
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp === qb.pop_front(), "bresp");
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata} === qr.pop_front(), "rdata");
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    qb.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // bready stays high: lowering it would collide with the next call
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    qr.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
  endtask
  task automatic pin(input int i, input logic v);
    en[i] <= 1;
    val[i] <= v;
    repeat (6) @(posedge aclk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    print_verdict();
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(48));
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h24, 34'h0);
    wr(8'h24, 32'hFFFF, RESP_OKAY);
    rd(8'h24, 34'h1FFF);
    wr(8'h40, 32'hFFFF, RESP_SLVERR);
    rd(8'h40, {RESP_SLVERR, 32'h0});
    chk(aux_oe === 3'b111, "aux oe");
    wr(8'h28, 32'h50, RESP_OKAY);
    chk(aux_out === 3'b101, "aux out");
    wr(8'h24, 32'h0, RESP_OKAY);
    r3 = 3'($urandom);
    ext <= r3;
    repeat (5) @(posedge aclk);
    chk({enc_index, enc_a, enc_b} === r3 && aux_oe === 3'b000, "encoder");
    rd(8'h28, 34'(r3) << 4);
    $display("registers done");
    pin(0, 0);
    s = pc[0];
    pin(1, 0);
    chk(pc[0] == s + 1 && step_dir === 1'b1, "step fall");
    pin(1, 1);
    chk(pc[0] == s + 1, "step rise");
    wr(8'h24, 32'h2, RESP_OKAY);
    repeat (6) @(posedge aclk);
    chk(pc[0] == s + 2, "inverted idle");
    pin(1, 0);
    pin(1, 1);
    chk(pc[0] == s + 3, "inverted step");
    $display("step done");
    for (int f = 0; f < 3; f++) begin
      wr(8'h24, 32'(f) << 8, RESP_OKAY);
      fault_event <= 1;
      @(posedge aclk);
      fault_event <= 0;
      rd(8'h80, 34'h11);
      s = pc[1];
      t = pc[2];
      u = pc[5];
      pin(2, 0);
      rd(8'h80, 34'(1 + 4 * (f == 0) + 8 * (f == 2)));
      chk(pc[1] == s + (f == 1) && pc[2] == t + (f == 2) && pc[5] == u + 1, "pin three");
      pin(2, 1);
      rd(8'h80, 34'h1);
    end
    thermal_event <= 1;
    overtemp_present <= 1;
    @(posedge aclk);
    thermal_event <= 0;
    pin(2, 0);
    rd(8'h80, 34'h29);
    pin(2, 1);
    overtemp_present <= 0;
    repeat (3) @(posedge aclk);
    rd(8'h80, 34'h1);
    $display("pin three done");
    wr(8'h24, 32'h400, RESP_OKAY);
    jog_active <= 1;
    s = pc[4];
    pin(3, 0);
    rd(8'h80, 34'h1);
    pin(3, 1);
    chk(pc[4] == s + 1, "flag");
    wr(8'h10, 32'h6, RESP_OKAY);
    pin(3, 0);
    chk(home_stop_now === 1'b0, "decelerate");
    rd(8'h80, 34'h3);
    pin(3, 1);
    rd(8'h80, 34'h1);
    jog_active <= 0;
    pin(3, 0);
    rd(8'h80, 34'h1);
    profile_start <= 1;
    @(posedge aclk);
    profile_start <= 0;
    profile_busy <= 1;
    pin(3, 1);
    rd(8'h80, 34'h3);
    profile_busy <= 0;
    wr(8'h24, 32'h0, RESP_OKAY);
    s = pc[3];
    pin(3, 0);
    chk(pc[3] == s + 1, "cutback");
    $display("pin two done");
    print_verdict();
  end
endmodule
`default_nettype wire
